// ==== scf_card_model.sv ====
// Card model: captures each host frame, answers after a short gap.
// Assumes the bench resolves the pulled-up CMD wire from both drivers.
module scf_card_model
(
    input  wire logic         i_clk,
    input  wire logic         i_cmd,
    input  wire logic [135:0] i_rsp,
    input  wire logic [7:0]   i_len,
    output logic              o_oe,
    output logic              o_bit,
    output logic [47:0]       o_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [47:0] sh;
    initial
    begin
        o_oe = 1'b0;
        o_bit = 1'b1;
        o_frame = '0;
        forever
        begin
            // Sample mid-bit, away from the host's launching edge
            @(negedge i_clk);
            if (i_cmd === 1'b0)
            begin
                sh = '0;
                for (int i = 0; i < 48; i++)
                begin
                    if (i > 0) @(negedge i_clk);
                    sh = {sh[46:0], i_cmd};
                end
                o_frame = sh;
                repeat (8) @(posedge i_clk);
                for (int i = int'(i_len) - 1; i >= 0; i--)
                begin
                    o_oe <= 1'b1;
                    o_bit <= i_rsp[i];
                    @(posedge i_clk);
                end
                o_oe <= 1'b0;
            end
        end
    end
endmodule // scf_card_model

// ==== scf_cmd_framer.sv ====
// Card command framer and response capture with SDIO read-wait control.
// Registers sit on i_core_clk; the CMD/DAT2 side runs on i_card_clk.
// Block-end, CRC-error and token inputs come from card-clock logic.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module scf_cmd_framer
(
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic              i_card_clk,
    input  wire scf_pkg::scf_bus_t i_bus,
    output logic [31:0]            o_rdata,
    input  wire logic              i_cmd_in,
    output logic                   o_cmd_out,
    output logic                   o_cmd_oe,
    output logic                   o_dat2_out,
    output logic                   o_dat2_oe,
    input  wire logic              i_blk_end,
    input  wire logic              i_blk_crc_err,
    input  wire logic              i_blk_last,
    input  wire logic              i_multi_read,
    input  wire logic              i_tok_valid,
    input  wire logic [7:0]        i_tok_byte
);

    // ************************************************************
    // Crossing registers
    // ************************************************************
    // Link to core: done toggle, token toggle, auto toggle, wait active
    logic [3:0] l2c_q;
    logic [3:0] l2c_s1_q;
    logic [3:0] l2c_s2_q;
    logic [3:0] l2c_s3_q;
    // Core to link: command toggle, request level, CRC enable level
    logic [2:0] c2l_q;
    logic [2:0] c2l_s1_q;
    logic [2:0] c2l_s2_q;
    logic [2:0] c2l_s3_q;
    logic       lrst_s1_q;
    logic       lrst_q;

    // ************************************************************
    // Core registers
    // ************************************************************
    scf_pkg::scf_cmd_t cmd_q;
    logic [31:0]       arg_q;
    logic [31:0]       rsp_q [4];
    logic [7:0]        rx_command_index_q;
    logic [7:0]        crc_token_byte_q;
    logic              rwrq_q;
    logic              rwcr_q;
    logic              busy_q;
    logic              cmd_tg_q;
    logic [31:0]       rdata_d;
    logic [31:0]       rdata_q;
    logic              done_ev;
    logic              tok_ev;
    logic              auto_ev;
    logic              cmd_wr;
    logic [39:0]       frame_head;

    // ************************************************************
    // Link registers
    // ************************************************************
    scf_pkg::scf_lst_t   st_q;
    logic [47:0]         tx_sh_q;
    logic [135:0]        rx_sh_q;
    logic [135:0]        rsp_buf_q;
    logic [7:0]          tok_buf_q;
    logic [7:0]          cnt_q;
    logic                cmd_out_q;
    logic                cmd_oe_q;
    logic                cmd_s1_q;
    logic                cmd_s2_q;
    logic                cmd_ev;
    logic                rw_wait_q;
    logic [1:0]          rw_cnt_q;
    logic                rw_act_q;
    logic                rw_seen_q;
    logic                done_tg_q;
    logic                tok_tg_q;
    logic                auto_tg_q;
    logic                auto_hit;
    logic                rw_start;
    logic                rw_release;

    assign done_ev    = l2c_s2_q[0] ^ l2c_s3_q[0];
    assign tok_ev     = l2c_s2_q[1] ^ l2c_s3_q[1];
    assign auto_ev    = l2c_s2_q[2] ^ l2c_s3_q[2];
    assign cmd_ev     = c2l_s2_q[0] ^ c2l_s3_q[0];
    assign cmd_wr     = i_bus.wr && (i_bus.addr == scf_pkg::OFF_CMD);
    assign frame_head = {scf_pkg::BIT_START, scf_pkg::BIT_HOST_DIR,
                         i_bus.wdata[scf_pkg::IDX_W-1:0], arg_q};

    // ************************************************************
    // Core-side synchronisers
    // ************************************************************
    always_ff @(posedge i_core_clk)
    begin
        l2c_s1_q <= l2c_q;
        l2c_s2_q <= l2c_s1_q;
        l2c_s3_q <= l2c_s2_q;
    end

    // ************************************************************
    // Command issue
    // ************************************************************
    // A command write while one is in flight is dropped: the frame register
    // is read by the link domain until the done toggle returns.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            cmd_q    <= '0;
            busy_q   <= 1'b0;
            cmd_tg_q <= 1'b0;
        end
        else if (cmd_wr && !busy_q)
        begin
            cmd_q.fmt   <= i_bus.wdata[scf_pkg::CMD_FMT_LSB +: 2];
            cmd_q.frame <= {frame_head, scf_pkg::scf_crc7(frame_head),
                            scf_pkg::BIT_END};
            busy_q      <= 1'b1;
            cmd_tg_q    <= ~cmd_tg_q;
        end
        else if (done_ev)
        begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            arg_q <= scf_pkg::RST_WORD;
        end
        else if (i_bus.wr && i_bus.addr == scf_pkg::OFF_ARG)
        begin
            arg_q <= i_bus.wdata;
        end
    end

    // ************************************************************
    // Response and token storage
    // ************************************************************
    // Software may write the response words; a response arriving in the same
    // cycle overwrites only the bits of that write that the response loads.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < 4; i++)
            begin
                rsp_q[i] <= scf_pkg::RST_WORD;
            end
            rx_command_index_q <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (i_bus.wr && i_bus.addr == scf_pkg::OFF_RSP01 + 8'(4 * i))
                begin
                    rsp_q[i] <= i_bus.wdata;
                end
            end
            if (done_ev && cmd_q.fmt == scf_pkg::FMT_R136)
            begin
                rx_command_index_q   <= rsp_buf_q[135:128];
                rsp_q[3] <= rsp_buf_q[127:96];
                rsp_q[2] <= rsp_buf_q[95:64];
                rsp_q[1] <= rsp_buf_q[63:32];
                rsp_q[0] <= rsp_buf_q[31:0];
            end
            else if (done_ev && cmd_q.fmt != scf_pkg::FMT_NONE)
            begin
                rx_command_index_q          <= rsp_buf_q[47:40];
                rsp_q[3]        <= rsp_buf_q[39:8];
                rsp_q[2][31:16] <= {8'h00, rsp_buf_q[7:0]};
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            crc_token_byte_q <= 8'h00;
        end
        else if (tok_ev)
        begin
            crc_token_byte_q <= tok_buf_q;
        end
    end

    // ************************************************************
    // Read-wait control
    // ************************************************************
    // The automatic set wins over a software clear in the same cycle.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            rwrq_q <= 1'b0;
            rwcr_q <= 1'b0;
        end
        else
        begin
            if (i_bus.wr && i_bus.addr == scf_pkg::OFF_RWCTL)
            begin
                rwrq_q <= i_bus.wdata[scf_pkg::RW_RQ_BIT];
                rwcr_q <= i_bus.wdata[scf_pkg::RW_CR_BIT];
            end
            if (auto_ev)
            begin
                rwrq_q <= 1'b1;
            end
        end
    end

    assign c2l_q = {rwcr_q, rwrq_q, cmd_tg_q};

    // ************************************************************
    // Register read port
    // ************************************************************
    always_comb
    begin
        rdata_d = scf_pkg::RST_WORD;
        unique case (i_bus.addr)
            scf_pkg::OFF_CMD:
                rdata_d = 32'({cmd_q.fmt, 3'h0, cmd_q.frame[45:40]});
            scf_pkg::OFF_ARG:   rdata_d = arg_q;
            scf_pkg::OFF_RSP01: rdata_d = rsp_q[0];
            scf_pkg::OFF_RSP23: rdata_d = rsp_q[1];
            scf_pkg::OFF_RSP45: rdata_d = rsp_q[2];
            scf_pkg::OFF_RSP67: rdata_d = rsp_q[3];
            scf_pkg::OFF_CRC_TOKEN_BYTE:  rdata_d = 32'(crc_token_byte_q);
            scf_pkg::OFF_RX_COMMAND_INDEX:  rdata_d = 32'(rx_command_index_q);
            scf_pkg::OFF_RWCTL: rdata_d = 32'({rwcr_q, rwrq_q});
            scf_pkg::OFF_STAT:
            begin
                rdata_d[scf_pkg::ST_BUSY_BIT]  = busy_q;
                rdata_d[scf_pkg::ST_RWACT_BIT] = l2c_s2_q[3];
            end
            default:            rdata_d = scf_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            rdata_q <= scf_pkg::RST_WORD;
        end
        else
        begin
            rdata_q <= i_bus.rd ? rdata_d : scf_pkg::RST_WORD;
        end
    end

    assign o_rdata = rdata_q;

    // ************************************************************
    // Link-side synchronisers and reset
    // ************************************************************
    always_ff @(posedge i_card_clk)
    begin
        lrst_s1_q <= i_reset;
        lrst_q    <= lrst_s1_q;
        c2l_s1_q  <= c2l_q;
        c2l_s2_q  <= c2l_s1_q;
        c2l_s3_q  <= c2l_s2_q;
        cmd_s1_q  <= i_cmd_in;
        cmd_s2_q  <= cmd_s1_q;
    end

    // ************************************************************
    // Command transmit and response receive
    // ************************************************************
    // No response timeout: a card that never answers leaves the block busy
    // until reset.
    always_ff @(posedge i_card_clk)
    begin
        if (lrst_q)
        begin
            st_q      <= scf_pkg::L_IDLE;
            tx_sh_q   <= '0;
            rx_sh_q   <= '0;
            rsp_buf_q <= '0;
            cnt_q     <= 8'h00;
            cmd_out_q <= scf_pkg::BIT_END;
            cmd_oe_q  <= 1'b0;
            done_tg_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                scf_pkg::L_IDLE:
                begin
                    cmd_oe_q <= 1'b0;
                    if (cmd_ev)
                    begin
                        tx_sh_q <= cmd_q.frame;
                        cnt_q   <= 8'(scf_pkg::FRAME_W - 1);
                        st_q    <= scf_pkg::L_TX;
                    end
                end
                scf_pkg::L_TX:
                begin
                    cmd_out_q <= tx_sh_q[scf_pkg::FRAME_W-1];
                    cmd_oe_q  <= 1'b1;
                    tx_sh_q   <= {tx_sh_q[46:0], 1'b0};
                    cnt_q     <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00)
                    begin
                        cnt_q <= 8'(scf_pkg::RX_GUARD);
                        if (cmd_q.fmt == scf_pkg::FMT_NONE)
                        begin
                            st_q      <= scf_pkg::L_IDLE;
                            done_tg_q <= ~done_tg_q;
                        end
                        else
                        begin
                            st_q <= scf_pkg::L_WAIT;
                        end
                    end
                end
                scf_pkg::L_WAIT:
                begin
                    // Guard cycles flush our own end bit out of the synchroniser
                    cmd_oe_q <= 1'b0;
                    if (cnt_q != 8'h00)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    else if (cmd_s2_q == scf_pkg::BIT_START)
                    begin
                        rx_sh_q <= {rx_sh_q[134:0], cmd_s2_q};
                        cnt_q   <= (cmd_q.fmt == scf_pkg::FMT_R136)
                                   ? 8'(scf_pkg::LONG_W - 2)
                                   : 8'(scf_pkg::FRAME_W - 2);
                        st_q    <= scf_pkg::L_RX;
                    end
                end
                scf_pkg::L_RX:
                begin
                    rx_sh_q <= {rx_sh_q[134:0], cmd_s2_q};
                    cnt_q   <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00)
                    begin
                        rsp_buf_q <= {rx_sh_q[134:0], cmd_s2_q};
                        done_tg_q <= ~done_tg_q;
                        st_q      <= scf_pkg::L_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_cmd_out = cmd_out_q;
    assign o_cmd_oe  = cmd_oe_q;

    // ************************************************************
    // Write CRC status token
    // ************************************************************
    always_ff @(posedge i_card_clk)
    begin
        if (lrst_q)
        begin
            tok_buf_q <= 8'h00;
            tok_tg_q  <= 1'b0;
        end
        else if (i_tok_valid)
        begin
            tok_buf_q <= i_tok_byte;
            tok_tg_q  <= ~tok_tg_q;
        end
    end

    // ************************************************************
    // Read wait on DAT2
    // ************************************************************
    assign auto_hit   = i_blk_end && i_blk_crc_err && c2l_s2_q[2]
                        && i_multi_read && !i_blk_last;
    assign rw_start   = i_blk_end && (c2l_s2_q[1] || auto_hit)
                        && !rw_wait_q && !rw_act_q;
    // Release only after the request has been seen set, so an automatic
    // start is not dropped before the core register catches up.
    assign rw_release = rw_act_q && rw_seen_q && !c2l_s2_q[1];

    always_ff @(posedge i_card_clk)
    begin
        if (lrst_q)
        begin
            rw_wait_q <= 1'b0;
            rw_cnt_q  <= 2'h0;
            rw_act_q  <= 1'b0;
            rw_seen_q <= 1'b0;
            auto_tg_q <= 1'b0;
        end
        else
        begin
            if (auto_hit)
            begin
                auto_tg_q <= ~auto_tg_q;
            end
            if (rw_start)
            begin
                rw_wait_q <= 1'b1;
                rw_cnt_q  <= 2'(scf_pkg::RW_DELAY - 1);
                rw_seen_q <= c2l_s2_q[1];
            end
            else if (rw_wait_q)
            begin
                rw_seen_q <= rw_seen_q || c2l_s2_q[1];
                rw_cnt_q  <= rw_cnt_q - 2'h1;
                if (rw_cnt_q == 2'h0)
                begin
                    rw_wait_q <= 1'b0;
                    rw_act_q  <= 1'b1;
                end
            end
            else if (rw_release)
            begin
                rw_act_q  <= 1'b0;
                rw_seen_q <= 1'b0;
            end
            else if (rw_act_q)
            begin
                rw_seen_q <= rw_seen_q || c2l_s2_q[1];
            end
        end
    end

    assign l2c_q      = {rw_act_q, auto_tg_q, tok_tg_q, done_tg_q};
    assign o_dat2_oe  = rw_act_q;
    assign o_dat2_out = scf_pkg::DAT2_WAIT;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_rw_armed;
        rw_start ##1 (rw_wait_q && !o_dat2_oe) ##1 (rw_wait_q && !o_dat2_oe);
    endsequence

    a_frame_fields: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (cmd_wr && !busy_q) |=> (cmd_q.frame[45:40] == $past(i_bus.wdata[5:0])
            && cmd_q.frame[39:8] == arg_q))
        else $error("command frame index or argument misplaced");

    a_frame_marks: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (cmd_wr && !busy_q) |=> (!cmd_q.frame[47] && cmd_q.frame[46] && cmd_q.frame[0]
            && cmd_q.frame[7:1] == scf_pkg::scf_crc7(cmd_q.frame[47:8])))
        else $error("command frame marks or CRC wrong");

    a_cmd_start: assert property (@(posedge i_card_clk) disable iff (lrst_q)
        (cmd_ev && st_q == scf_pkg::L_IDLE)
        |-> ##2 (o_cmd_oe && !o_cmd_out) ##1 (o_cmd_oe && o_cmd_out))
        else $error("command start and direction bits not sent");

    a_arg_kept: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !(i_bus.wr && i_bus.addr == scf_pkg::OFF_ARG) |=> $stable(arg_q))
        else $error("argument register changed without write");

    a_short_rsp: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (done_ev && (cmd_q.fmt == scf_pkg::FMT_R48 || cmd_q.fmt == scf_pkg::FMT_R48_NC))
        |=> (rx_command_index_q == $past(rsp_buf_q[47:40]) && rsp_q[3] == $past(rsp_buf_q[39:8])
            && rsp_q[2][31:16] == {8'h00, $past(rsp_buf_q[7:0])}))
        else $error("short response stored wrongly");

    a_long_rsp: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (done_ev && cmd_q.fmt == scf_pkg::FMT_R136)
        |=> (rx_command_index_q == $past(rsp_buf_q[135:128]) && rsp_q[0] == $past(rsp_buf_q[31:0])))
        else $error("long response stored wrongly");

    a_token_store: assert property (@(posedge i_core_clk) disable iff (i_reset)
        tok_ev |=> crc_token_byte_q == $past(tok_buf_q))
        else $error("CRC status token not captured");

    a_auto_request: assert property (@(posedge i_core_clk) disable iff (i_reset)
        auto_ev |=> rwrq_q)
        else $error("automatic read wait did not set request");

    a_rw_delay: assert property (@(posedge i_card_clk) disable iff (lrst_q)
        s_rw_armed |=> o_dat2_oe && !o_dat2_out)
        else $error("read wait not driven two clocks after block end");

    a_rw_release: assert property (@(posedge i_card_clk) disable iff (lrst_q)
        rw_release && !rw_start |=> !o_dat2_oe)
        else $error("DAT2 not released after request cleared");

    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_bus.rd && (i_bus.addr == scf_pkg::OFF_RX_COMMAND_INDEX || i_bus.addr == scf_pkg::OFF_CRC_TOKEN_BYTE))
        |=> o_rdata[31:8] == 24'h000000)
        else $error("reserved bits read nonzero");

endmodule // scf_cmd_framer

// ==== scf_pkg.sv ====
// Shared constants and carrier types of the card command/response framer.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package scf_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFF_CMD   = 8'h00;
    localparam logic [7:0] OFF_ARG   = 8'h04;
    localparam logic [7:0] OFF_RSP01 = 8'h08;
    localparam logic [7:0] OFF_RSP23 = 8'h0c;
    localparam logic [7:0] OFF_RSP45 = 8'h10;
    localparam logic [7:0] OFF_RSP67 = 8'h14;
    localparam logic [7:0] OFF_CRC_TOKEN_BYTE  = 8'h18;
    localparam logic [7:0] OFF_RX_COMMAND_INDEX  = 8'h1c;
    localparam logic [7:0] OFF_RWCTL = 8'h20;
    localparam logic [7:0] OFF_STAT  = 8'h24;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int         CMD_FMT_LSB  = 9;
    localparam int         IDX_W        = 6;
    localparam int         RW_RQ_BIT    = 0;
    localparam int         RW_CR_BIT    = 1;
    localparam int         ST_BUSY_BIT  = 0;
    localparam int         ST_RWACT_BIT = 2;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [1:0] FMT_NONE     = 2'h0;
    localparam logic [1:0] FMT_R48      = 2'h1;
    localparam logic [1:0] FMT_R136     = 2'h2;
    localparam logic [1:0] FMT_R48_NC   = 2'h3;

    // ************************************************************
    // Frame layout and timing
    // ************************************************************
    localparam int         FRAME_W      = 48;
    localparam int         LONG_W       = 136;
    localparam int         CRC_W        = 7;
    localparam logic [6:0] CRC_POLY     = 7'h09;
    localparam logic       BIT_START    = 1'b0;
    localparam logic       BIT_HOST_DIR = 1'b1;
    localparam logic       BIT_END      = 1'b1;
    localparam logic       DAT2_WAIT    = 1'b0;
    localparam int         RW_DELAY     = 2;
    localparam int         RX_GUARD     = 2;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scf_bus_t;

    typedef struct packed {
        logic [1:0]         fmt;
        logic [FRAME_W-1:0] frame;
    } scf_cmd_t;

    typedef enum logic [1:0] {L_IDLE, L_TX, L_WAIT, L_RX} scf_lst_t;

    // Serial CRC7, most significant bit first, over the 40 leading frame bits
    function automatic logic [6:0] scf_crc7(input logic [39:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
        end
        return c;
    endfunction

endpackage

// ==== test_scf_cmd_framer.sv ====
// Bench of the framer: register port on the core clock, card on CMD.
// Assumes the card model answers every command with the set response.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module test_scf_cmd_framer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, cclk = 0, rst = 1, cmd, h_out, h_oe, c_oe, c_bit;
    logic d_out, d_oe, bend = 0, berr = 0, last = 0, multi = 1, tv = 0;
    logic [7:0] tb = 0, len = 48;
    logic [31:0] rdata;
    logic [47:0] frame;
    logic [135:0] rsp = 0;
    scf_pkg::scf_bus_t bus = '0;
    int n_errors = 0, check_count = 0, cyc = 0;
    assign cmd = h_oe ? h_out : (c_oe ? c_bit : 1'b1);
    scf_cmd_framer scf_cmd_framer_i (.i_core_clk(clk), .i_reset(rst), .i_card_clk(cclk),
        .i_bus(bus), .o_rdata(rdata), .i_cmd_in(cmd), .o_cmd_out(h_out), .o_cmd_oe(h_oe),
        .o_dat2_out(d_out), .o_dat2_oe(d_oe), .i_blk_end(bend), .i_blk_crc_err(berr),
        .i_blk_last(last), .i_multi_read(multi), .i_tok_valid(tv), .i_tok_byte(tb));
    scf_card_model scf_card_model_i (.i_clk(cclk), .i_cmd(cmd), .i_rsp(rsp), .i_len(len),
        .o_oe(c_oe), .o_bit(c_bit), .o_frame(frame));
    initial forever #50 clk = ~clk;
    initial
    begin
        #3;
        forever #6 cclk = ~cclk;
    end
    function automatic logic [6:0] crc(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        return c;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic t_cmd(input logic [1:0] f, input logic [5:0] x, input logic [31:0] a);
        logic [31:0] v;
        v = 32'h1;
        wr(8'h04, a);
        wr(8'h00, {21'h0, f, 3'h0, x});
        for (int i = 0; i < 60 && v[0] !== 1'b0; i++) rd(8'h24, v);
        `CHK(v[0], 1'b0)
        `CHK(frame, {2'b01, x, a, crc({2'b01, x, a}), 1'b1})
        rd(8'h04, v);
        `CHK(v, a)
        rd(8'h1c, v);
        `CHK(v, {24'h0, rsp[len-1 -: 8]})
    endtask
    task automatic blk(input logic e, input logic l);
        @(posedge cclk);
        bend <= 1'b1;
        berr <= e;
        last <= l;
        @(posedge cclk);
        bend <= 1'b0;
        @(posedge cclk);
        #1 `CHK(d_oe, 1'b0)
        @(posedge cclk);
        #1 `CHK({d_oe, d_out}, {!l, 1'b0})
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 20000) begin n_errors++; give_verdict(); end
    initial
    begin
        logic [31:0] v;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h40, v);
        `CHK(v, 32'h0)
        rsp[47:0] = {8'h2a, 32'hdead_beef, 8'h5b};
        t_cmd(2'h1, 6'h2a, 32'h1234_abcd);
        rd(8'h14, v);
        `CHK(v, 32'hdead_beef)
        rd(8'h10, v);
        `CHK(v, 32'h005b_0000)
        len = 136;
        rsp = {8'h3f, 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff};
        t_cmd(2'h2, 6'h02, 32'hffff_0001);
        for (int k = 0; k < 4; k++)
        begin
            rd(8'h14 - 8'(4 * k), v);
            `CHK(v, rsp[127 - 32 * k -: 32])
        end
        @(posedge cclk);
        tv <= 1'b1;
        tb <= 8'he5;
        @(posedge cclk);
        tv <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'h18, v);
        `CHK(v, 32'h0000_00e5)
        wr(8'h20, 32'h1);
        repeat (4) @(posedge clk);
        blk(1'b0, 1'b0);
        wr(8'h20, 32'h2);
        repeat (4) @(posedge clk);
        `CHK(d_oe, 1'b0)
        blk(1'b1, 1'b0);
        repeat (6) @(posedge clk);
        rd(8'h20, v);
        `CHK(v, 32'h3)
        rd(8'h24, v);
        `CHK(v, 32'h4)
        wr(8'h20, 32'h2);
        repeat (4) @(posedge clk);
        `CHK(d_oe, 1'b0)
        blk(1'b1, 1'b1);
        repeat (6) @(posedge clk);
        rd(8'h20, v);
        `CHK(v, 32'h2)
        give_verdict();
    end
endmodule // test_scf_cmd_framer
